/* ist_defines.svh */
`ifndef IST_DEFINES_SVH
`define IST_DEFINES_SVH
`define IST_OFS_STATUS 12'h000
`define IST_OFS_CONFIG 12'h004
`define IST_OFS_CALL   12'h008
`define IST_OFS_TXDATA 12'h00c
`define IST_CFG_RST    32'h0000_0000
`define IST_CMD_UNL    8'h3f
`define IST_CMD_UNT    8'h5f
`define IST_CMD_LLO    8'h11
`define IST_CMD_GTL    8'h01
`define IST_CMD_GET    8'h08
`define IST_CMD_DCL    8'h14
`define IST_CMD_SDC    8'h04
`define IST_CMD_TCT    8'h09
`define IST_GRP_LISTEN 3'h1
`define IST_GRP_TALK   3'h2
`define IST_GRP_SEC    3'h3
`define IST_POLL_RQS   6
`define IST_TX_LAST    8
`endif

/* ist_pkg.sv */
package ist_pkg;

    typedef enum logic [3:0] {
        OP_NONE, OP_ONLINE, OP_GO_LOCAL, OP_BUS_INIT, OP_STANDBY, OP_POLL,
        OP_POLL_READ, OP_WAIT, OP_READ, OP_WRITE, OP_CMD, OP_IO_DONE, OP_OTHER
    } ist_op_t;

    typedef struct packed {
        logic       atn;
        logic       ren;
        logic       srq;
        logic       ifc;
        logic       eoi;
        logic       dav;
        logic [7:0] dio;
    } ist_lines_t;

    typedef struct packed {
        logic [11:0] rsv;
        logic [7:0]  poll;
        logic        mask_clear_seen;
        logic        mask_trigger_seen;
        logic        mask_time_limit_flag;
        logic        shadow;
        logic        dev_op;
        logic        timed_out;
        logic        fatal;
        logic        err;
        logic [3:0]  op;
    } ist_call_t;

    typedef struct packed {
        logic [7:0] rsv;
        logic       sad_en;
        logic [4:0] sad;
        logic [4:0] pad;
        logic       sys_ctrl;
        logic       dma;
        logic       eot_en;
        logic       eos_wr_eoi;
        logic       eos_rd_end;
        logic [7:0] terminator_char;
    } ist_cfg_t;

endpackage : ist_pkg

/* ist_status_tracker.sv */
// Register access over APB and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`include "ist_defines.svh"
module ist_status_tracker
    import ist_pkg::*;
#(
    parameter bit SRQ_ALWAYS = 1'b0
)
(
    input  wire logic        i_core_clk,
    input  wire logic        i_rstn,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    input  wire logic [3:0]  i_pstrb,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    input  wire ist_lines_t  i_bus,
    output logic      [15:0] o_status,
    output logic      [7:0]  o_tx_data,
    output logic             o_tx_valid,
    output logic             o_tx_eoi,
    output logic             o_read_term,
    output logic             o_dma_sel
);

    ist_lines_t  lines_s1_ff;
    ist_lines_t  lines_s2_ff;
    logic        dav_d_ff;
    logic        ren_d_ff;
    logic        ifc_d_ff;
    ist_cfg_t    cfg_ff;
    logic [31:0] prdata_ff;
    logic        pready_ff;
    logic        pslverr_ff;
    logic [15:0] status_ff;
    logic [7:0]  tx_data_ff;
    logic        tx_valid_ff;
    logic        tx_eoi_ff;
    logic        read_term_ff;
    logic        err_ff;
    logic        fatal_ff;
    logic        time_limit_flag_ff;
    logic        end_ff;
    logic        rqs_ff;
    logic        busy_ff;
    logic        lok_ff;
    logic        rem_ff;
    logic        cic_ff;
    logic        talker_addressed_ff;
    logic        listener_addressed_ff;
    logic        trigger_seen_ff;
    logic        clear_seen_ff;
    logic        reading_ff;
    logic        shadow_ff;
    logic        devop_ff;
    logic        sec_pend_ff;
    logic        trigger_seen_pend_ff;
    logic        clear_seen_pend_ff;

    // Bus line synchroniser
    always_ff @(posedge i_core_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            lines_s1_ff <= '0;
            lines_s2_ff <= '0;
            dav_d_ff    <= 1'b0;
            ren_d_ff    <= 1'b0;
            ifc_d_ff    <= 1'b0;
        end
        else
        begin
            lines_s1_ff <= i_bus;
            lines_s2_ff <= lines_s1_ff;
            dav_d_ff    <= lines_s2_ff.dav;
            ren_d_ff    <= lines_s2_ff.ren;
            ifc_d_ff    <= lines_s2_ff.ifc;
        end
    end

    // Bus byte and command decode
    wire ist_lines_t ln       = lines_s2_ff;
    wire [7:0]       bb       = ln.dio;
    wire             byte_stb = ln.dav & ~dav_d_ff;
    wire             cmd_stb  = byte_stb & ln.atn;
    wire             data_stb = byte_stb & ~ln.atn;
    wire             ren_fall = ~ln.ren & ren_d_ff;
    wire             ifc_rise = ln.ifc & ~ifc_d_ff;
    wire             ifc_ext  = ifc_rise & ~cfg_ff.sys_ctrl;
    wire             is_unl   = cmd_stb & (bb == `IST_CMD_UNL);
    wire             is_unt   = cmd_stb & (bb == `IST_CMD_UNT);
    wire             is_llo   = cmd_stb & (bb == `IST_CMD_LLO);
    wire             is_gtl   = cmd_stb & (bb == `IST_CMD_GTL);
    wire             is_get   = cmd_stb & (bb == `IST_CMD_GET);
    wire             is_dcl   = cmd_stb & (bb == `IST_CMD_DCL);
    wire             is_sdc   = cmd_stb & (bb == `IST_CMD_SDC);
    wire             is_tct   = cmd_stb & (bb == `IST_CMD_TCT);
    wire             is_mla   = cmd_stb & (bb == {`IST_GRP_LISTEN, cfg_ff.pad});
    wire             is_mta   = cmd_stb & (bb == {`IST_GRP_TALK, cfg_ff.pad});
    wire             is_ota   = cmd_stb & (bb[7:5] == `IST_GRP_TALK) & ~is_mta;
    wire             is_msa   = cmd_stb & sec_pend_ff & (bb == {`IST_GRP_SEC, cfg_ff.sad});
    wire             eos_in   = cfg_ff.eos_rd_end & (bb == cfg_ff.terminator_char);
    wire             term_hit = data_stb & (ln.eoi | eos_in);

    // Register access decode
    wire acc      = i_psel & i_penable;
    wire commit   = acc & pready_ff;
    wire sel_stat = (i_paddr == `IST_OFS_STATUS);
    wire sel_cfg  = (i_paddr == `IST_OFS_CONFIG);
    wire sel_call = (i_paddr == `IST_OFS_CALL);
    wire sel_tx   = (i_paddr == `IST_OFS_TXDATA);
    wire bad_acc  = ~(sel_cfg | sel_call | sel_tx | (sel_stat & ~i_pwrite));
    wire call_wr  = commit & i_pwrite & sel_call;
    wire tx_wr    = commit & i_pwrite & sel_tx;
    wire cfg_wr   = commit & i_pwrite & sel_cfg;

    wire ist_call_t call    = ist_call_t'(i_pwdata);
    wire ist_op_t   op      = ist_op_t'(call.op);
    wire            c_on    = call_wr & (op == OP_ONLINE);
    wire            c_wait  = op == OP_WAIT;
    wire            c_rd    = op == OP_READ;
    wire            c_wr    = op == OP_WRITE;
    wire            io_strt = call_wr & (c_rd | c_wr | (op == OP_CMD));
    wire            io_done = call_wr & (op == OP_IO_DONE);
    wire            c_stby  = call_wr & (op == OP_STANDBY);
    wire            c_local = call_wr & (op == OP_GO_LOCAL);

    // Flag updates, set dominates clear
    wire nxt_err     = call_wr ? (call.err | call.fatal) : err_ff;
    wire nxt_fatal   = call_wr ? call.fatal : fatal_ff;
    wire nxt_time_limit_flag    = call_wr ? (call.timed_out & (~c_wait | call.mask_time_limit_flag)) : time_limit_flag_ff;
    wire nxt_end     = ((reading_ff | shadow_ff) & term_hit)
                       | (end_ff & ~(io_strt | c_on));
    wire nxt_rqs     = (call_wr & (op == OP_POLL) & call.dev_op & call.poll[`IST_POLL_RQS])
                       | (rqs_ff & ~(call_wr & (op == OP_POLL_READ)));
    wire nxt_busy    = io_strt | (busy_ff & ~io_done);
    wire nxt_reading = (io_strt & c_rd) | (reading_ff & ~(io_done | term_hit));
    wire nxt_shadow  = (c_stby & call.shadow)
                       | (shadow_ff & ~((c_stby & ~call.shadow) | io_strt | c_on));
    wire nxt_lok     = is_llo | (lok_ff & ~(ren_fall | c_on));
    wire nxt_rem     = (ln.ren & is_mla)
                       | (rem_ff & ~(ren_fall | (is_gtl & listener_addressed_ff)
                                     | (c_local & ~lok_ff) | c_on));
    wire cic_in      = (call_wr & (op == OP_BUS_INIT) & cfg_ff.sys_ctrl)
                       | (is_tct & talker_addressed_ff & ~cic_ff);
    wire nxt_cic     = cic_in | (cic_ff & ~(ifc_ext | (is_tct & ~talker_addressed_ff) | c_on));
    wire nxt_talker_addressed    = is_mta | (talker_addressed_ff & ~(is_unt | is_ota | ifc_rise | c_on));
    wire listener_addressed_set    = (is_mla & ~cfg_ff.sad_en) | is_msa | (c_stby & call.shadow);
    wire listener_addressed_clr    = is_unl | is_mta | ifc_rise | (c_stby & ~call.shadow) | c_on;
    wire nxt_listener_addressed    = listener_addressed_set | (listener_addressed_ff & ~listener_addressed_clr);
    wire nxt_trigger_seen    = (is_get & listener_addressed_ff) | (trigger_seen_ff & ~((call_wr & trigger_seen_pend_ff) | c_on));
    wire nxt_clear_seen    = is_dcl | (is_sdc & listener_addressed_ff)
                       | (clear_seen_ff & ~((call_wr & clear_seen_pend_ff) | c_on));
    wire srq_seen    = ln.srq & (cic_ff | SRQ_ALWAYS)
                       & ~(SRQ_ALWAYS == 1'b0 & busy_ff & ~devop_ff & talker_addressed_ff & ~ln.atn);

    // Status word assembly
    wire [15:0] word_full = {err_ff, time_limit_flag_ff, end_ff, srq_seen, rqs_ff & devop_ff,
                             2'b00,
                             ~busy_ff, lok_ff, rem_ff, cic_ff, ln.atn,
                             talker_addressed_ff, listener_addressed_ff, trigger_seen_ff, clear_seen_ff};
    wire [15:0] word      = fatal_ff ? {err_ff, 15'h0000} : word_full;

    wire [31:0] rd_mux = sel_stat ? {16'h0000, word} :
                         sel_cfg  ? cfg_ff :
                                    32'h0000_0000;
    wire        tx_eoi = (i_pwdata[`IST_TX_LAST] & cfg_ff.eot_en)
                         | (cfg_ff.eos_wr_eoi & (i_pwdata[7:0] == cfg_ff.terminator_char));

    // Bus slave, one wait state
    always_ff @(posedge i_core_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            pready_ff  <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end
        else
        begin
            pready_ff  <= acc & ~pready_ff;
            prdata_ff  <= (acc & ~pready_ff & ~i_pwrite) ? rd_mux : 32'h0000_0000;
            pslverr_ff <= acc & ~pready_ff & bad_acc;
        end
    end

    // Configuration byte lanes
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1)
        begin : g_cfg_lane
            always_ff @(posedge i_core_clk or negedge i_rstn)
            begin
                if (!i_rstn)
                    cfg_ff[gi*8 +: 8] <= 8'(`IST_CFG_RST >> (gi*8));
                else if (cfg_wr & i_pstrb[gi])
                    cfg_ff[gi*8 +: 8] <= i_pwdata[gi*8 +: 8];
            end
        end
    endgenerate

    // Status flags
    always_ff @(posedge i_core_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            {err_ff, fatal_ff, time_limit_flag_ff, end_ff, rqs_ff, busy_ff} <= 6'h00;
            {lok_ff, rem_ff, cic_ff, talker_addressed_ff, listener_addressed_ff, trigger_seen_ff, clear_seen_ff} <= 7'h00;
            {reading_ff, shadow_ff, devop_ff, sec_pend_ff} <= 4'h0;
            {trigger_seen_pend_ff, clear_seen_pend_ff} <= 2'h0;
            status_ff <= 16'h0000;
        end
        else
        begin
            {err_ff, fatal_ff, time_limit_flag_ff} <= {nxt_err, nxt_fatal, nxt_time_limit_flag};
            {end_ff, rqs_ff, busy_ff} <= {nxt_end, nxt_rqs, nxt_busy};
            {lok_ff, rem_ff, cic_ff} <= {nxt_lok, nxt_rem, nxt_cic};
            {talker_addressed_ff, listener_addressed_ff, trigger_seen_ff, clear_seen_ff} <= {nxt_talker_addressed, nxt_listener_addressed, nxt_trigger_seen, nxt_clear_seen};
            {reading_ff, shadow_ff} <= {nxt_reading, nxt_shadow};
            devop_ff <= call_wr ? call.dev_op : devop_ff;
            sec_pend_ff <= cmd_stb ? (is_mla & cfg_ff.sad_en) : sec_pend_ff;
            trigger_seen_pend_ff <= call_wr ? (c_wait & call.mask_trigger_seen) : trigger_seen_pend_ff;
            clear_seen_pend_ff <= call_wr ? ((c_wait & call.mask_clear_seen) | c_rd | c_wr)
                                    : clear_seen_pend_ff;
            status_ff <= word;
        end
    end

    // Outgoing byte and read termination
    always_ff @(posedge i_core_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            tx_data_ff   <= 8'h00;
            tx_valid_ff  <= 1'b0;
            tx_eoi_ff    <= 1'b0;
            read_term_ff <= 1'b0;
        end
        else
        begin
            tx_data_ff   <= tx_wr ? i_pwdata[7:0] : tx_data_ff;
            tx_valid_ff  <= tx_wr;
            tx_eoi_ff    <= tx_wr & tx_eoi;
            read_term_ff <= reading_ff & term_hit;
        end
    end

    assign o_prdata    = prdata_ff;
    assign o_pready    = pready_ff;
    assign o_pslverr   = pslverr_ff;
    assign o_status    = status_ff;
    assign o_tx_data   = tx_data_ff;
    assign o_tx_valid  = tx_valid_ff;
    assign o_tx_eoi    = tx_eoi_ff;
    assign o_read_term = read_term_ff;
    assign o_dma_sel   = cfg_ff.dma;

    // Checks
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rstn);

    sequence s_setup;
        i_psel & ~i_penable;
    endsequence
    sequence s_access;
        i_psel & i_penable;
    endsequence
    sequence s_fatal_call;
        call_wr & call.fatal;
    endsequence

    a_apb_ready_one: assert property (s_setup ##1 s_access |-> ##1 o_pready)
        else $error("access not answered after one wait state");
    a_fault_after: assert property (call_wr & call.err |=> err_ff ##1 o_status[15])
        else $error("fault flag missing after erroring call");
    a_fatal_only: assert property (s_fatal_call |=> ##1 o_status == 16'h8000)
        else $error("fatal outcome left other bits set");
    a_spare_zero: assert property (o_status[10:9] == 2'b00)
        else $error("unused status bits not zero");
    a_busy_done: assert property (io_strt |=> ##1 ~o_status[8])
        else $error("io done shown during transfer");
    a_end_clear: assert property (io_strt & ~term_hit |=> ~end_ff)
        else $error("end flag survived new transfer");
    a_lock_release: assert property (ren_fall & ~is_llo |=> ~lok_ff)
        else $error("lockout kept after REN release");
    a_local_blocked: assert property (c_local & lok_ff & rem_ff & ~ren_fall & ~c_on
                                      |=> rem_ff)
        else $error("go local acted under lockout");
    a_atn_track: assert property ($rose(lines_s2_ff.atn) & ~fatal_ff |=> status_ff[4])
        else $error("attention bit not following line");
    a_talk_clear: assert property (is_unt |=> ~talker_addressed_ff)
        else $error("talker flag kept after untalk");
    a_online_clear: assert property (c_on & ~cmd_stb & ~data_stb
                                     |=> ~(lok_ff | talker_addressed_ff | listener_addressed_ff | cic_ff))
        else $error("online call left flags set");
    a_last_eoi: assert property (tx_wr & i_pwdata[`IST_TX_LAST] & cfg_ff.eot_en
                                 |=> o_tx_eoi & o_tx_valid)
        else $error("EOI missing on last byte");

endmodule : ist_status_tracker

/* ist_bus_model.sv */
`timescale 1ns/100ps
module ist_bus_model
    import ist_pkg::*;
(
    input  wire logic i_core_clk,
    output ist_lines_t o_bus
);
    initial o_bus = '0;

    // One handshake byte; dio and eoi driven to inverse two cycles after dav falls, atn held
    task automatic send(input logic [7:0] b, input logic a, input logic e);
        @(posedge i_core_clk);
        o_bus.dio <= b;
        o_bus.atn <= a;
        o_bus.eoi <= e;
        repeat (3) @(posedge i_core_clk);
        o_bus.dav <= 1'b1;
        repeat (3) @(posedge i_core_clk);
        o_bus.dav <= 1'b0;
        repeat (2) @(posedge i_core_clk);
        o_bus.dio <= ~b;
        o_bus.eoi <= ~e;
        repeat (6) @(posedge i_core_clk);
    endtask : send

    // Level lines, then settle time for the sync flops
    task automatic lines(input logic a, input logic r, input logic s, input logic i);
        @(posedge i_core_clk);
        o_bus.atn <= a;
        o_bus.ren <= r;
        o_bus.srq <= s;
        o_bus.ifc <= i;
        repeat (6) @(posedge i_core_clk);
    endtask : lines
endmodule : ist_bus_model

/* tb_top.sv */
`timescale 1ns/100ps
module tb_top
    import ist_pkg::*;
;
    logic        clk     = 1'b0;
    logic        rstn    = 1'b0;
    logic        psel    = 1'b0;
    logic        pen     = 1'b0;
    logic        pwr     = 1'b0;
    logic [11:0] padr    = 12'h000;
    logic [31:0] pwd     = 32'h0;
    ist_lines_t  bus;
    logic [31:0] prdata;
    logic        pready, pslverr, txv, txe, rterm, dmas;
    logic [15:0] sts;
    logic [7:0]  txd, terminator_char, la, ta, bx;
    logic [4:0]  pad;
    logic [31:0] cfg;
    logic [15:0] st      = 16'h0100;
    logic [32:0] exp_q[$];
    logic [8:0]  tx_q[$];
    logic [3:0]  op_t[6] = '{OP_OTHER, OP_OTHER, OP_OTHER, OP_WAIT, OP_WAIT, OP_OTHER};
    logic [7:0]  fl_t[6] = '{8'h01, 8'h00, 8'h04, 8'h04, 8'h24, 8'h00};
    logic [15:0] st_t[6] = '{16'h8100, 16'h0100, 16'h4100, 16'h0100, 16'h4100, 16'h0100};
    int          error_cnt = 0;
    int          checked   = 0;
    int          terms     = 0;

    always #2 clk = ~clk;

    ist_status_tracker #(.SRQ_ALWAYS(1'b0)) dut (
        .i_core_clk(clk), .i_rstn(rstn), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
        .i_paddr(padr), .i_pwdata(pwd), .i_pstrb(4'hf), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_bus(bus), .o_status(sts),
        .o_tx_data(txd), .o_tx_valid(txv), .o_tx_eoi(txe), .o_read_term(rterm),
        .o_dma_sel(dmas)
    );

    ist_bus_model bm (.i_core_clk(clk), .o_bus(bus));

    task automatic chk(input logic [32:0] g, input logic [32:0] e);
        checked++;
        if (g !== e)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    task automatic close_out;
        $display("errors %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : close_out

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [31:0] e, input logic er);
        exp_q.push_back({e, er});
        @(posedge clk);
        psel <= 1'b1;
        pwr  <= w;
        padr <= a;
        pwd  <= d;
        @(posedge clk);
        pen <= 1'b1;
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask : apb

    task automatic rd_st;
        apb(1'b0, 12'h000, 32'h0, {16'h0, st}, 1'b0);
        chk({17'h0, sts}, {17'h0, st});
    endtask : rd_st

    task automatic call(input logic [3:0] op, input logic [7:0] fl, input logic [7:0] pb);
        apb(1'b1, 12'h008, {12'h0, pb, fl, op}, 32'h0, 1'b0);
    endtask : call

    task automatic tx(input logic last, input logic [7:0] b, input logic e);
        tx_q.push_back({e, b});
        apb(1'b1, 12'h00c, {23'h0, last, b}, 32'h0, 1'b0);
    endtask : tx

    // Answer and outgoing byte checker
    always @(posedge clk)
    begin
        if (pready === 1'b1)
            chk({prdata, pslverr}, exp_q.size() ? exp_q.pop_front() : 33'h1ffffffff);
        if (txv === 1'b1)
            chk({24'h0, txe, txd}, tx_q.size() ? {24'h0, tx_q.pop_front()} : 33'h1ff);
        if (rterm === 1'b1)
            terms++;
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        close_out();
    end

    initial
    begin
        void'($urandom(32'h2bd1));
        terminator_char = 8'($urandom);
        pad = 5'($urandom_range(29, 1));
        la  = {3'h1, pad};
        ta  = {3'h2, pad};
        cfg = {8'h0, 1'b0, 5'h0, pad, 1'b1, 1'($urandom), 1'b1, 1'b1, 1'b1, terminator_char};
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
        rd_st;
        apb(1'b1, 12'h000, 32'hffff, 32'h0, 1'b1);
        apb(1'b0, 12'h010, 32'h0, 32'h0, 1'b1);
        apb(1'b0, 12'h004, 32'h0, 32'h0, 1'b0);
        apb(1'b1, 12'h004, cfg, 32'h0, 1'b0);
        apb(1'b0, 12'h004, 32'h0, cfg, 1'b0);
        chk({32'h0, dmas}, {32'h0, cfg[11]});
        rd_st;
        for (int i = 0; i < 6; i++)
        begin
            call(op_t[i], fl_t[i], 8'h00);
            st = st_t[i];
            rd_st;
        end
        bm.lines(1'b1, 1'b1, 1'b0, 1'b0);
        st |= 16'h0010;
        rd_st;
        bm.send(la, 1'b1, 1'b0);
        st |= 16'h0044;
        rd_st;
        bm.send(8'h11, 1'b1, 1'b0);
        st |= 16'h0080;
        call(OP_GO_LOCAL, 8'h00, 8'h00);
        rd_st;
        bm.send(8'h08, 1'b1, 1'b0);
        bm.send(8'h14, 1'b1, 1'b0);
        st |= 16'h0003;
        rd_st;
        call(OP_OTHER, 8'h02, 8'h00);
        apb(1'b0, 12'h000, 32'h0, 32'h8000, 1'b0);
        call(OP_WAIT, 8'hc0, 8'h00);
        rd_st;
        call(OP_OTHER, 8'h00, 8'h00);
        st &= ~16'h0003;
        rd_st;
        bm.send(ta, 1'b1, 1'b0);
        st = (st | 16'h0008) & ~16'h0004;
        rd_st;
        bm.send(8'h5f, 1'b1, 1'b0);
        bm.send(la, 1'b1, 1'b0);
        st = (st | 16'h0004) & ~16'h0008;
        rd_st;
        bm.send(8'h3f, 1'b1, 1'b0);
        st &= ~16'h0004;
        rd_st;
        bm.lines(1'b1, 1'b0, 1'b0, 1'b0);
        st &= ~16'h00c0;
        rd_st;
        bm.lines(1'b1, 1'b1, 1'b0, 1'b0);
        bm.send(la, 1'b1, 1'b0);
        bm.send(8'h01, 1'b1, 1'b0);
        bm.send(8'h3f, 1'b1, 1'b0);
        call(OP_BUS_INIT, 8'h00, 8'h00);
        st |= 16'h0020;
        rd_st;
        bm.lines(1'b1, 1'b1, 1'b1, 1'b0);
        st |= 16'h1000;
        rd_st;
        bm.lines(1'b1, 1'b1, 1'b0, 1'b0);
        st &= ~16'h1000;
        rd_st;
        bm.send(8'h09, 1'b1, 1'b0);
        st &= ~16'h0020;
        rd_st;
        call(OP_BUS_INIT, 8'h00, 8'h00);
        bm.send(la, 1'b1, 1'b0);
        bm.send(8'h11, 1'b1, 1'b0);
        call(OP_ONLINE, 8'h00, 8'h00);
        rd_st;
        bm.lines(1'b1, 1'b1, 1'b1, 1'b0);
        rd_st;
        bm.lines(1'b1, 1'b1, 1'b0, 1'b0);
        call(OP_POLL, 8'h08, 8'h40);
        st |= 16'h0800;
        rd_st;
        call(OP_POLL_READ, 8'h08, 8'h00);
        st &= ~16'h0800;
        rd_st;
        call(OP_POLL, 8'h08, 8'hbf);
        rd_st;
        bm.send(la, 1'b1, 1'b0);
        bm.lines(1'b0, 1'b1, 1'b0, 1'b0);
        st = (st | 16'h0044) & ~16'h0010;
        call(OP_READ, 8'h00, 8'h00);
        st &= ~16'h0100;
        rd_st;
        bm.send(terminator_char, 1'b0, 1'b0);
        call(OP_IO_DONE, 8'h00, 8'h00);
        st |= 16'h2100;
        rd_st;
        call(OP_READ, 8'h00, 8'h00);
        st &= ~16'h2100;
        rd_st;
        bm.send(terminator_char ^ 8'h01, 1'b0, 1'b1);
        call(OP_IO_DONE, 8'h00, 8'h00);
        st |= 16'h2100;
        rd_st;
        chk({1'b0, 32'(terms)}, 33'h2);
        bm.lines(1'b0, 1'b1, 1'b0, 1'b1);
        st &= ~16'h0004;
        rd_st;
        bm.lines(1'b0, 1'b1, 1'b0, 1'b0);
        bx = terminator_char ^ 8'h5a;
        tx(1'b1, bx, 1'b1);
        tx(1'b0, terminator_char, 1'b1);
        tx(1'b0, bx, 1'b0);
        repeat (4) @(posedge clk);
        chk({32'h0, tx_q.size() == 0}, 33'h1);
        close_out();
    end
endmodule : tb_top
